// file: msc_defines.svh
// constants for the module sideband control block
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH
// ==========================================================
// clock and timing
`define MSC_CLK_MHZ 40
`define MSC_T_RESET_INIT_NS 2000
`define MSC_T_INIT_NS 2000000
`define MSC_CNT_W 20
// ==========================================================
// register indices (byte address is four times the index)
`define MSC_AW 12
`define MSC_IDX_W 10
`define MSC_IDX_STATUS 10'h002
`define MSC_IDX_FLAGS 10'h003
`define MSC_IDX_CTRL 10'h05d
// ==========================================================
// field positions and reset values
`define MSC_ST_NOT_READY 0
`define MSC_ST_LOW_POWER 1
`define MSC_CTRL_OVERRIDE 0
`define MSC_CTRL_POWER_SET 1
`define MSC_CTRL_HP_ALLOW 2
`define MSC_CTRL_W 3
`define MSC_CTRL_RST 3'h0
`define MSC_FLAG_W 8
`define MSC_FLAG_RST 8'h00
`define MSC_SYNC_W 6
`define MSC_SYNC_RST 6'h15
`endif

// file: msc_host.sv
// host board model driving the module sideband pins
`timescale 1ns/1ps
`default_nettype none
module msc_host #(
  parameter int SEL_WAIT = 6 // host pause after a select change, cycles
) (
  input wire logic ref_clk, // block clock
  input wire logic interrupt_n_o, // module interrupt level
  input wire logic interrupt_n_oe_n, // module interrupt enable, low drives
  output wire logic module_select_n, // select pin level
  output wire logic module_select_n_drv, // select pin driven
  output wire logic module_reset_n, // reset pin level
  output wire logic module_reset_n_drv, // reset pin driven
  output wire logic low_power_request, // low-power pin level
  output wire logic low_power_request_drv, // low-power pin driven
  output wire logic int_pin // interrupt wire as the host sees it
);
  // index 0 select, 1 reset, 2 low power; start low so a float is never high by luck
  logic [2:0] lvl = 3'h0; // last level put on each pin
  logic [2:0] drv = 3'h0; // all pins undriven at insertion
  assign {low_power_request, module_reset_n, module_select_n} = lvl;
  assign {low_power_request_drv, module_reset_n_drv, module_select_n_drv} = drv;
  // board pull-up supplies the high level
  assign int_pin = interrupt_n_oe_n | interrupt_n_o;
  // m: 0 release, 1 drive low, 2 drive high; a released pin shows its stale level inverted
  task automatic pin(input int p, input int m);
    @(posedge ref_clk);
    drv[p] <= (m != 0);
    lvl[p] <= (m == 0) ? ~lvl[p] : (m == 2);
    if (p == 0)
    begin
      repeat (SEL_WAIT) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: msc_pkg.sv
// types for the module sideband control block
`default_nettype none
package msc_pkg;
  // reset sequencer states
  typedef enum logic [1:0] {MSC_RUN, MSC_HOLD, MSC_INIT} msc_rst_st_t;
endpackage
`default_nettype wire

// file: msc_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module msc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk, // block clock
  input wire logic resetn, // async reset, active low
  input wire logic [W-1:0] d_async, // levels from outside the domain
  output logic [W-1:0] q_sync // levels safe to use
);
  logic [W-1:0] meta_r; // first stage, read only by the second
  // ==========================================================
  // sampling stages
  // both stages reset to the idle pin level so no false event at release
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= RST_VAL;
      q_sync <= RST_VAL;
    end
    else
    begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: msc_top.sv
// sideband control and status logic of a pluggable transceiver module
// How it works
// - select low enables management interface answers
// - select high silences management interface completely
// - undriven select reads high, deselected
// - undriven reset pin reads as released
// - long reset pulse restores all defaults
// - init interval starts at reset release
// - completion: interrupt low, not-ready clear
// - power-up posts completion without reset pulse
// - low-power pin pulled up, high means low power
// - power state from pin and control bits
// - presence pin driven low while inserted
// - interrupt low flags fault or status
// - interrupt is pull-low-only open collector
// - release after not-ready zero and flags read
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "msc_defines.svh"
`default_nettype none
module msc_top #(
  parameter int INIT_CYC = (`MSC_T_INIT_NS * `MSC_CLK_MHZ) / 1000
) (
  input wire logic ref_clk, // 40 MHz block clock
  input wire logic resetn, // power-on reset, async, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high writes
  input wire logic [`MSC_AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  input wire logic module_select_n, // select pin level, active low
  input wire logic module_select_n_drv, // host drives the select pin
  input wire logic module_reset_n, // reset pin level, active low
  input wire logic module_reset_n_drv, // host drives the reset pin
  input wire logic low_power_request, // low-power pin level
  input wire logic low_power_request_drv, // host drives the low-power pin
  input wire logic [`MSC_FLAG_W-1:0] fault_event, // one-cycle fault pulses
  output logic module_present_n_o, // presence pin output level
  output logic module_present_n_oe_n, // presence pin enable, low drives
  output logic interrupt_n_o, // interrupt pin output level
  output logic interrupt_n_oe_n, // interrupt pin enable, low drives
  output logic mgmt_enable, // management engine may answer
  output logic low_power_mode, // module held in low power
  output logic high_power_enable, // high power classes allowed
  output logic init_busy // reset execution in progress
);
  // ==========================================================
  // timing counts
  localparam int PULSE_CYC = (`MSC_T_RESET_INIT_NS * `MSC_CLK_MHZ + 999) / 1000;
  localparam logic [`MSC_CNT_W-1:0] PULSE_MAX = PULSE_CYC[`MSC_CNT_W-1:0];
  localparam logic [`MSC_CNT_W-1:0] INIT_MAX = INIT_CYC[`MSC_CNT_W-1:0];

  // ==========================================================
  // pin conditioning
  logic [`MSC_SYNC_W-1:0] pins_async; // raw pins and drive flags
  logic [`MSC_SYNC_W-1:0] pins_sync; // synchronised copies
  wire logic sel_lvl; // biased select level
  wire logic rst_lvl; // biased reset level
  wire logic lp_lvl; // biased low-power level

  assign pins_async = {low_power_request_drv, low_power_request,
                       module_reset_n_drv, module_reset_n,
                       module_select_n_drv, module_select_n};

  // drive flags reset to undriven, levels to their pulled-up state
  msc_sync #(
    .W(`MSC_SYNC_W),
    .RST_VAL(`MSC_SYNC_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d_async(pins_async),
    .q_sync(pins_sync)
  );

  // an undriven pin reads high: the internal bias
  assign sel_lvl = pins_sync[1] ? pins_sync[0] : 1'b1;
  assign rst_lvl = pins_sync[3] ? pins_sync[2] : 1'b1;
  assign lp_lvl = pins_sync[5] ? pins_sync[4] : 1'b1;

  // ==========================================================
  // register decode
  function automatic logic reg_hit(input logic [`MSC_AW-1:0] a,
                                   input logic [`MSC_IDX_W-1:0] idx);
    reg_hit = (a[`MSC_AW-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  wire logic hit_status; // status word addressed
  wire logic hit_flags; // flag word addressed
  wire logic hit_ctrl; // power control word addressed
  wire logic hit_any; // any mapped word
  wire logic access_done; // apb transfer completes at this edge
  wire logic wr_ctrl; // completing write to control
  wire logic rd_status; // completing read of status
  wire logic rd_flags; // completing read of flags

  assign hit_status = reg_hit(paddr, `MSC_IDX_STATUS);
  assign hit_flags = reg_hit(paddr, `MSC_IDX_FLAGS);
  assign hit_ctrl = reg_hit(paddr, `MSC_IDX_CTRL);
  assign hit_any = hit_status | hit_flags | hit_ctrl;
  assign access_done = psel & penable & pready;
  assign wr_ctrl = access_done & pwrite & hit_ctrl;
  assign rd_status = access_done & ~pwrite & hit_status;
  assign rd_flags = access_done & ~pwrite & hit_flags;

  // ==========================================================
  // reset sequencer state
  msc_pkg::msc_rst_st_t st_r; // sequencer state
  msc_pkg::msc_rst_st_t st_nxt; // next state
  logic [`MSC_CNT_W-1:0] cnt_r; // pulse or init cycle count
  logic [`MSC_CNT_W-1:0] cnt_nxt; // next count
  logic full_reset; // pulse was long enough, defaults restored now
  logic init_end; // reset execution finished this cycle

  // sequencer: measure the low pulse, then time the execution
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    full_reset = 1'b0;
    init_end = 1'b0;
    unique case (st_r)
      msc_pkg::MSC_RUN:
      begin
        // start measuring as soon as the pin goes low
        if (!rst_lvl)
        begin
          st_nxt = msc_pkg::MSC_HOLD;
          cnt_nxt = '0;
        end
      end
      msc_pkg::MSC_HOLD:
      begin
        if (!rst_lvl)
        begin
          // saturate so a very long pulse stays armed
          if (cnt_r != PULSE_MAX)
            cnt_nxt = cnt_r + 1'b1;
        end
        else if (cnt_r == PULSE_MAX)
        begin
          // execution starts at the rising edge of the pin
          st_nxt = msc_pkg::MSC_INIT;
          cnt_nxt = '0;
          full_reset = 1'b1;
        end
        else
        begin
          // short glitch: ignored, nothing is reset
          st_nxt = msc_pkg::MSC_RUN;
        end
      end
      msc_pkg::MSC_INIT:
      begin
        if (!rst_lvl)
        begin
          // a new pulse during execution restarts the measurement
          st_nxt = msc_pkg::MSC_HOLD;
          cnt_nxt = '0;
        end
        else if (cnt_r == INIT_MAX - 1'b1)
        begin
          st_nxt = msc_pkg::MSC_RUN;
          init_end = 1'b1;
        end
        else
          cnt_nxt = cnt_r + 1'b1;
      end
    endcase
  end

  // power-up enters execution directly so completion posts unasked
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= msc_pkg::MSC_INIT;
      cnt_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // status, flags and control registers
  logic not_ready_r; // data not ready flag
  logic not_ready_nxt;
  logic done_pend_r; // completion interrupt still posted
  logic done_pend_nxt;
  logic st_zero_r; // status seen with not-ready clear
  logic st_zero_nxt;
  logic [`MSC_FLAG_W-1:0] flags_r; // sticky fault flags
  logic [`MSC_FLAG_W-1:0] flags_nxt;
  logic [`MSC_CTRL_W-1:0] ctrl_r; // power control bits
  logic [`MSC_CTRL_W-1:0] ctrl_nxt;
  wire logic lp_active; // resolved low-power state

  // override selects the software bit over the pin
  assign lp_active = ctrl_r[`MSC_CTRL_OVERRIDE] ?
                     ctrl_r[`MSC_CTRL_POWER_SET] : lp_lvl;

  // not-ready is set by full reset and cleared when execution ends
  assign not_ready_nxt = full_reset ? 1'b1 : (init_end ? 1'b0 : not_ready_r);
  // completion posts at the end of execution; set wins over release
  assign done_pend_nxt = init_end ? 1'b1 :
                         ((full_reset | (rd_flags & st_zero_r)) ? 1'b0 :
                          done_pend_r);
  // remember a status read that showed not-ready at zero
  assign st_zero_nxt = (full_reset | init_end) ? 1'b0 :
                       ((rd_status & ~prdata[`MSC_ST_NOT_READY]) ? 1'b1 :
                        ((rd_flags & st_zero_r) ? 1'b0 : st_zero_r));
  // read clears only what was reported; a new event in that cycle stays
  assign flags_nxt = full_reset ? `MSC_FLAG_RST :
                     ((flags_r & ~(rd_flags ? prdata[`MSC_FLAG_W-1:0] :
                       `MSC_FLAG_RST)) | fault_event);
  assign ctrl_nxt = full_reset ? `MSC_CTRL_RST :
                    (wr_ctrl ? pwdata[`MSC_CTRL_W-1:0] : ctrl_r);

  // state registers, power-up values match a fresh execution
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      not_ready_r <= 1'b1;
      done_pend_r <= 1'b0;
      st_zero_r <= 1'b0;
      flags_r <= `MSC_FLAG_RST;
      ctrl_r <= `MSC_CTRL_RST;
    end
    else
    begin
      not_ready_r <= not_ready_nxt;
      done_pend_r <= done_pend_nxt;
      st_zero_r <= st_zero_nxt;
      flags_r <= flags_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================
  // apb slave
  wire logic [31:0] rd_mux; // read data for the addressed word
  wire logic ready_nxt; // ready after one wait cycle

  assign rd_mux = hit_status ? {30'h0, lp_active, not_ready_r} :
                  hit_flags ? {24'h0, flags_r} :
                  hit_ctrl ? {29'h0, ctrl_r} : 32'h0;
  // one wait state: ready rises in the second access cycle
  assign ready_nxt = psel & penable & ~pready;

  // read data captured with ready so it is stable for the sample
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= ready_nxt;
      pslverr <= ready_nxt & ~hit_any;
      // keep data through the completing cycle, zero otherwise
      if (ready_nxt)
        prdata <= pwrite ? 32'h0 : rd_mux;
      else if (!pready)
        prdata <= 32'h0;
    end
  end

  // ==========================================================
  // sideband outputs
  wire logic int_req; // any reason to pull the interrupt low

  assign int_req = done_pend_r | (|flags_r);

  // every output registered; open-collector pins only ever pull low
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      module_present_n_o <= 1'b0;
      module_present_n_oe_n <= 1'b0;
      interrupt_n_o <= 1'b0;
      interrupt_n_oe_n <= 1'b1;
      mgmt_enable <= 1'b0;
      low_power_mode <= 1'b1;
      high_power_enable <= 1'b0;
      init_busy <= 1'b1;
    end
    else
    begin
      module_present_n_o <= 1'b0;
      module_present_n_oe_n <= 1'b0;
      interrupt_n_o <= 1'b0;
      interrupt_n_oe_n <= ~int_req;
      // the engine answers only while selected; timing waits are the host's
      mgmt_enable <= ~sel_lvl;
      low_power_mode <= lp_active;
      high_power_enable <= ~lp_active & ctrl_r[`MSC_CTRL_HP_ALLOW];
      init_busy <= not_ready_nxt;
    end
  end
endmodule
`default_nettype wire

// file: msc_top_bench.sv
// self-checking bench for the sideband control block
`timescale 1ns/1ps
`include "msc_defines.svh"
`default_nettype none
module msc_top_bench;
  localparam int INIT = 20; // shortened reset execution
  localparam logic [11:0] A_ST = {`MSC_IDX_STATUS, 2'b00}; // status word
  localparam logic [11:0] A_FL = {`MSC_IDX_FLAGS, 2'b00}; // flag word
  localparam logic [11:0] A_CT = {`MSC_IDX_CTRL, 2'b00}; // control word
  logic ref_clk = 1'b0; // 40 MHz
  logic resetn = 1'b0; // power-on reset
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [11:0] paddr = '0; // apb address
  logic [31:0] pwdata = '0; // apb write data
  logic [7:0] fault_event = '0; // fault pulses
  logic [31:0] prdata, rd; // bus data and last read
  logic pready, pslverr, er; // bus answer and last error
  logic sel_n, sel_d, rst_n, rst_d, lp, lp_d, int_pin; // host pins
  logic pres_o, pres_oe, int_o, int_oe, mgmt_enable, low_power_mode, high_power_enable, init_busy;
  int mismatches = 0;
  int comparisons = 0;
  msc_top #(.INIT_CYC(INIT)) dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .module_select_n(sel_n), .module_select_n_drv(sel_d),
    .module_reset_n(rst_n), .module_reset_n_drv(rst_d), .low_power_request(lp),
    .low_power_request_drv(lp_d), .fault_event(fault_event), .module_present_n_o(pres_o),
    .module_present_n_oe_n(pres_oe), .interrupt_n_o(int_o), .interrupt_n_oe_n(int_oe),
    .mgmt_enable(mgmt_enable), .low_power_mode(low_power_mode),
    .high_power_enable(high_power_enable), .init_busy(init_busy));
  msc_host host (.ref_clk(ref_clk), .interrupt_n_o(int_o), .interrupt_n_oe_n(int_oe),
    .module_select_n(sel_n), .module_select_n_drv(sel_d), .module_reset_n(rst_n),
    .module_reset_n_drv(rst_d), .low_power_request(lp), .low_power_request_drv(lp_d),
    .int_pin(int_pin));
  initial forever #12.5 ref_clk = ~ref_clk;
  // compare just after the edge so registered outputs have landed
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    #1;
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request stands until pready is sampled high
  // no cycle count is assumed: a slave that never answers is left to the watchdog
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // measure the reset execution from pin or power release
  task automatic init_run(input int pre);
    int k;
    k = pre;
    repeat (pre) @(posedge ref_clk);
    while (init_busy === 1'b1 && k < 1000)
    begin
      @(posedge ref_clk);
      k++;
    end
    cmp(k >= INIT - 1 && k <= INIT + 8, 1);
  endtask
  // completion handshake; status is only read once execution is over
  task automatic done_seq;
    repeat (3) @(posedge ref_clk);
    cmp(int_pin, 0);
    apb(0, A_ST, 0);
    cmp(rd[0], 0);
    cmp(int_pin, 0);
    apb(0, A_FL, 0);
    cmp(rd, 0);
    repeat (3) @(posedge ref_clk);
    cmp(int_pin, 1);
  endtask
  // the pin floats low from insertion and after release from high,
  // so only the internal bias keeps the engine deselected there
  task automatic sel_test;
    cmp(mgmt_enable, 0);
    host.pin(0, 1);
    cmp(mgmt_enable, 1);
    host.pin(0, 2);
    cmp(mgmt_enable, 0);
    host.pin(0, 0);
    cmp(mgmt_enable, 0);
  endtask
  // every control code against both pin levels
  task automatic pow_test;
    cmp(low_power_mode, 1);
    for (int i = 0; i < 16; i++)
    begin
      logic el, eh;
      host.pin(2, i[3] ? 2 : 1);
      apb(1, A_CT, {29'h0, i[2:0]});
      repeat (5) @(posedge ref_clk);
      el = i[0] ? i[1] : i[3];
      eh = !el && i[2];
      cmp({low_power_mode, high_power_enable}, {el, eh});
      apb(0, A_ST, 0);
      cmp(rd[1], el);
    end
    apb(1, A_CT, 0);
    host.pin(2, 0);
    repeat (5) @(posedge ref_clk);
    cmp(low_power_mode, 1);
  endtask
  task automatic fault_test;
    @(posedge ref_clk);
    fault_event <= 8'h08;
    @(posedge ref_clk);
    fault_event <= 8'h00;
    repeat (3) @(posedge ref_clk);
    cmp(int_pin, 0);
    apb(0, A_FL, 0);
    cmp(rd, 32'h8);
    repeat (3) @(posedge ref_clk);
    cmp(int_pin, 1);
    apb(0, A_FL, 0);
    cmp(rd, 0);
    // a new event in the cycle of its clearing read must survive the read
    @(posedge ref_clk);
    fault_event <= 8'h01;
    @(posedge ref_clk);
    fault_event <= 8'h00;
    fork
      apb(0, A_FL, 0);
      begin
        repeat (3) @(posedge ref_clk);
        fault_event <= 8'h01;
        @(posedge ref_clk);
        fault_event <= 8'h00;
      end
    join
    cmp(rd, 32'h1);
    cmp(int_pin, 0);
    apb(0, A_FL, 0);
    cmp(rd, 32'h1);
    apb(0, A_FL, 0);
    cmp(rd, 0);
  endtask
  // unmapped and misaligned places answer with an error and no effect
  task automatic err_test;
    apb(0, 12'h100, 0);
    cmp({rd[30:0], er}, 1);
    apb(1, A_CT + 12'h2, 5);
    cmp(er, 1);
    apb(0, A_CT, 0);
    cmp(rd, 0);
  endtask
  task automatic pin_reset_test;
    apb(1, A_CT, 5);
    host.pin(1, 1);
    repeat (40) @(posedge ref_clk);
    host.pin(1, 2);
    repeat (8) @(posedge ref_clk);
    cmp(init_busy, 0);
    apb(0, A_CT, 0);
    cmp(rd, 5);
    host.pin(1, 1);
    repeat (100) @(posedge ref_clk);
    host.pin(1, 2);
    init_run(4);
    apb(0, A_CT, 0);
    cmp(rd, 0);
    done_seq;
    host.pin(1, 0);
    repeat (100) @(posedge ref_clk);
    cmp(init_busy, 0);
    // a floating pin read as low would turn this rising edge into a full reset
    host.pin(1, 2);
    repeat (8) @(posedge ref_clk);
    cmp(init_busy, 0);
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    init_run(0);
    done_seq;
    apb(0, A_CT, 0);
    cmp(rd, `MSC_CTRL_RST);
    sel_test;
    pow_test;
    fault_test;
    err_test;
    pin_reset_test;
    final_report;
  end
  // hang guard at 20000 cycles, well beyond the few hundred cycles the run needs
  initial
  begin
    #(25 * 20000);
    mismatches++;
    final_report;
  end
endmodule
bind msc_top msc_top_chk #(.INIT_CYC(INIT_CYC)) chk (.ref_clk(ref_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .module_select_n(module_select_n),
  .module_select_n_drv(module_select_n_drv), .fault_event(fault_event),
  .module_present_n_o(module_present_n_o), .module_present_n_oe_n(module_present_n_oe_n),
  .interrupt_n_o(interrupt_n_o), .interrupt_n_oe_n(interrupt_n_oe_n),
  .mgmt_enable(mgmt_enable), .low_power_mode(low_power_mode),
  .high_power_enable(high_power_enable), .init_busy(init_busy));
`default_nettype wire

// file: msc_top_chk.sv
// assertions on the sideband control ports
`timescale 1ns/1ps
`include "msc_defines.svh"
`default_nettype none
module msc_top_chk #(
  parameter int INIT_CYC = 20 // reset execution length, cycles
) (
  input wire logic ref_clk, // block clock
  input wire logic resetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [`MSC_AW-1:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic module_select_n, // select pin level
  input wire logic module_select_n_drv, // select pin driven
  input wire logic [`MSC_FLAG_W-1:0] fault_event, // fault pulses
  input wire logic module_present_n_o, // presence level
  input wire logic module_present_n_oe_n, // presence enable
  input wire logic interrupt_n_o, // interrupt level
  input wire logic interrupt_n_oe_n, // interrupt enable
  input wire logic mgmt_enable, // engine may answer
  input wire logic low_power_mode, // low power active
  input wire logic high_power_enable, // high power allowed
  input wire logic init_busy // reset execution running
);
  logic sel_eff; // select level after the internal bias
  logic rd_flags; // completing read of the flag register
  logic [`MSC_CNT_W-1:0] busy_cnt; // length of the current busy stretch
  assign sel_eff = !(module_select_n_drv && !module_select_n);
  assign rd_flags = psel && pready && !pwrite && (paddr == {`MSC_IDX_FLAGS, 2'b00});
  // counts busy cycles so a short execution is caught
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      busy_cnt <= '0;
    else
      busy_cnt <= init_busy ? busy_cnt + 1'b1 : '0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  present_low_a: assert property (!module_present_n_o && !module_present_n_oe_n)
    else $error("presence pin not held low");
  int_low_only_a: assert property (!interrupt_n_o)
    else $error("interrupt pin driven high");
  sel_answer_a: assert property ($fell(sel_eff) |-> ##3 mgmt_enable)
    else $error("select did not enable management");
  sel_silent_a: assert property ($rose(sel_eff) |-> ##3 !mgmt_enable)
    else $error("deselect did not silence management");
  hp_excl_a: assert property (high_power_enable |-> !low_power_mode)
    else $error("high power while in low power");
  done_irq_a: assert property ($fell(init_busy) |-> ##[1:3] !interrupt_n_oe_n)
    else $error("no completion interrupt");
  init_len_a: assert property ($fell(init_busy) |-> $past(busy_cnt) >= INIT_CYC - 2)
    else $error("reset execution too short");
  irq_release_a: assert property ($rose(interrupt_n_oe_n) |-> $past(rd_flags) || $past(rd_flags, 2))
    else $error("interrupt released without flag read");
  fault_irq_a: assert property ((|fault_event) |-> ##[1:3] !interrupt_n_oe_n)
    else $error("fault did not pull interrupt low");
  ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb wait state wrong");
endmodule
`default_nettype wire
